/* File: hdl/ddr_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module ddr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clock,   // core clock
   input  wire logic             i_rst_n,   // async reset
   input  wire logic             i_ce,      // clock enable
   input  wire logic             i_valid,   // push request
   output logic                  o_ready,   // not full
   input  wire logic [WIDTH-1:0] i_data,    // push data
   output logic                  o_valid,   // not empty
   input  wire logic             i_ready,   // pop accept
   output logic      [WIDTH-1:0] o_data     // head data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   wire push = i_valid && o_ready;
   wire pop  = o_valid && i_ready;
   assign o_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign o_valid = wp_q != rp_q;
   assign o_data  = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else if (i_ce) begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop)  rp_q <= rp_q + 1'b1;
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_ce && push) mem_q[wp_q[AW-1:0]] <= i_data;
   end
endmodule // ddr_fifo

/* File: hdl/ddr_params.svh */
// constants for the ddr sdram command and data model
`ifndef DDR_PARAMS_SVH
`define DDR_PARAMS_SVH
`define DDR_ROW_W        13
`define DDR_COL_W        10
`define DDR_DQ_W         8
`define DDR_BANKS        4
`define DDR_MEM_DEPTH    64
`define DDR_MEM_AW       6
`define DDR_FIFO_DEPTH   8
`define DDR_MR_BL_LSB    0
`define DDR_MR_BT_BIT    3
`define DDR_MR_CL_LSB    4
`define DDR_BL_2         3'h1
`define DDR_BL_4         3'h2
`define DDR_BL_8         3'h3
`define DDR_CL_2         3'h2
`define DDR_CL_25        3'h6
`define DDR_MR_RESET     13'h0022
`define DDR_AP_BIT       10
`endif

/* File: hdl/ddr_pkg.sv */
// types shared by the ddr sdram model
package ddr_pkg;
   typedef enum logic [2:0] {
      DDR_CMD_NOP, DDR_CMD_ACT, DDR_CMD_RD, DDR_CMD_WR,
      DDR_CMD_BST, DDR_CMD_PRE, DDR_CMD_REF, DDR_CMD_MRS
   } ddr_cmd_e;
   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  bank_select;
      logic [12:0] address_inputs;
   } ddr_cmd_s;
   typedef struct packed {
      logic [7:0] data;
      logic       write_data_mask;
   } ddr_beat_s;
endpackage

/* File: hdl/ddr_sdram.sv */
// ddr sdram device model: command decode, banks, mode register and ddr data
`timescale 1ns/10ps
`include "ddr_params.svh"
module ddr_sdram import ddr_pkg::*; #(
   parameter int MEM_AW = `DDR_MEM_AW
) (
   input  wire logic           i_clock,      // core clock, 100 MHz
   input  wire logic           i_rst_n,      // async reset, active low
   input  wire logic           i_ce,         // core clock enable
   input  wire logic           i_mclk,       // memory clock pin
   input  wire logic           i_cke,        // memory clock enable pin
   input  wire ddr_cmd_s       i_cmd,        // command and address pins
   input  wire logic [7:0]     i_dq,         // data pin inputs
   output logic      [7:0]     o_dq,         // data pin outputs
   output logic                o_dq_oe_n,    // data drive enable, low drives
   input  wire logic           i_dqs,        // strobe pin input
   output logic                o_dqs,        // strobe pin output
   output logic                o_dqs_oe_n,   // strobe drive enable, low drives
   input  wire logic           i_write_data_mask, // write mask pin
   output logic                o_wr_ready,   // write buffer has room
   output logic      [3:0]     o_bank_open,  // open row flags per bank
   output logic                o_power_down  // in power-down or self refresh
);
   localparam int DEPTH = 1 << MEM_AW;
   // pin synchronisers: three stages for clock, enable and strobe, two for command and data; an edge counts while stages 2 and 3 differ
   logic [2:0]  mclk_s_q, cke_s_q, dqs_s_q;
   ddr_cmd_s    cmd_s1_q, cmd_s2_q;
   logic [8:0]  wd_s1_q, wd_s2_q;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mclk_s_q <= 3'h0;
         cke_s_q  <= 3'h0;
         dqs_s_q  <= 3'h0;
         cmd_s1_q <= '1;
         cmd_s2_q <= '1;
         wd_s1_q  <= 9'h000;
         wd_s2_q  <= 9'h000;
      end else if (i_ce) begin
         mclk_s_q <= {mclk_s_q[1:0], i_mclk};
         cke_s_q  <= {cke_s_q[1:0], i_cke};
         dqs_s_q  <= {dqs_s_q[1:0], i_dqs};
         cmd_s1_q <= i_cmd;
         cmd_s2_q <= cmd_s1_q;
         wd_s1_q  <= {i_dq, i_write_data_mask};
         wd_s2_q  <= wd_s1_q;
      end
   end
   wire mclk_rise = mclk_s_q[1] && !mclk_s_q[2];
   wire mclk_fall = !mclk_s_q[1] && mclk_s_q[2];
   wire dqs_edge  = dqs_s_q[1] != dqs_s_q[2];
   wire cke_now   = cke_s_q[2];
   // command decode; with chip select high everything decodes as no-op
   ddr_cmd_e cmd;
   always_comb begin
      cmd = DDR_CMD_NOP;
      if (!cmd_s2_q.cs_n) begin
         case ({cmd_s2_q.ras_n, cmd_s2_q.cas_n, cmd_s2_q.we_n})
            3'h3:    cmd = DDR_CMD_ACT;
            3'h5:    cmd = DDR_CMD_RD;
            3'h4:    cmd = DDR_CMD_WR;
            3'h6:    cmd = DDR_CMD_BST;
            3'h2:    cmd = DDR_CMD_PRE;
            3'h1:    cmd = DDR_CMD_REF;
            3'h0:    cmd = DDR_CMD_MRS;
            default: cmd = DDR_CMD_NOP;
         endcase
      end
   end
   // power-down gates the command receiver; strobe and data beats still reach the write fifo, which drains only when awake
   logic pd_q;
   wire  act = mclk_rise && !pd_q && cke_now;
   wire [1:0]  ba   = cmd_s2_q.bank_select;
   wire [12:0] addr = cmd_s2_q.address_inputs;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) pd_q <= 1'b1;
      else if (i_ce && mclk_rise) pd_q <= !cke_now;
   end
   // mode register
   logic [12:0] mr_q;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) mr_q <= `DDR_MR_RESET;
      else if (i_ce && act && cmd == DDR_CMD_MRS && ba == 2'h0) mr_q <= addr;
   end
   wire [2:0] bl_code = mr_q[`DDR_MR_BL_LSB +: 3];
   wire       interl  = mr_q[`DDR_MR_BT_BIT];
   wire       cl_half = mr_q[`DDR_MR_CL_LSB +: 3] == `DDR_CL_25;
   wire [3:0] bl = (bl_code == `DDR_BL_8) ? 4'h8 :
                   (bl_code == `DDR_BL_4) ? 4'h4 : 4'h2;
   // bank state; open rows kept per bank
   logic [3:0]  open_q;
   logic [12:0] row_q [4];
   logic        ap_q;
   logic [1:0]  ap_bank_q;
   logic        burst_done;
   genvar gb;
   for (gb = 0; gb < 4; gb++) begin : g_bank
      always_ff @(posedge i_clock or negedge i_rst_n) begin
         if (!i_rst_n) begin
            open_q[gb] <= 1'b0;
            row_q[gb]  <= 13'h0000;
         end else if (i_ce) begin
            if (act && cmd == DDR_CMD_ACT && ba == 2'(gb)) begin
               open_q[gb] <= 1'b1;
               row_q[gb]  <= addr;
            end else if (act && cmd == DDR_CMD_PRE &&
                         (addr[`DDR_AP_BIT] || ba == 2'(gb))) begin
               open_q[gb] <= 1'b0;
            end else if (burst_done && ap_q && ap_bank_q == 2'(gb)) begin
               open_q[gb] <= 1'b0;
            end
         end
      end
   end
   // burst engine
   typedef enum logic [1:0] {DDR_ST_IDLE, DDR_ST_LAT, DDR_ST_RD, DDR_ST_WR} ddr_st_e;
   ddr_st_e     st_q;
   logic [3:0]  beat_q;
   logic [3:0]  len_q;
   logic [2:0]  start_q;
   logic [MEM_AW-1:0] base_q;
   logic [2:0]  lat_q;
   logic        half_q;
   wire rw_cmd = act && (cmd == DDR_CMD_RD || cmd == DDR_CMD_WR);
   assign burst_done = (st_q == DDR_ST_RD || st_q == DDR_ST_WR) && beat_q == len_q;
   // burst order within the aligned block
   logic [2:0] ofs;
   always_comb begin
      logic [2:0] msk;
      msk = 3'(len_q - 4'h1);
      ofs = 3'h0;
      if (interl) ofs = (start_q ^ beat_q[2:0]) & msk;
      else        ofs = (start_q + beat_q[2:0]) & msk;
   end
   wire [MEM_AW-1:0] mem_idx = (base_q & ~MEM_AW'(len_q - 4'h1)) | MEM_AW'(ofs);
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q      <= DDR_ST_IDLE;
         beat_q    <= 4'h0;
         len_q     <= 4'h2;
         start_q   <= 3'h0;
         base_q    <= '0;
         lat_q     <= 3'h0;
         half_q    <= 1'b0;
         ap_q      <= 1'b0;
         ap_bank_q <= 2'h0;
      end else if (i_ce) begin
         if (rw_cmd && open_q[ba]) begin
            st_q      <= (cmd == DDR_CMD_RD) ? DDR_ST_LAT : DDR_ST_WR;
            beat_q    <= 4'h0;
            len_q     <= bl;
            start_q   <= addr[2:0] & 3'(bl - 4'h1);
            base_q    <= MEM_AW'({ba, addr[3:0]});
            lat_q     <= 3'h0;
            half_q    <= cl_half;
            ap_q      <= addr[`DDR_AP_BIT];
            ap_bank_q <= ba;
         end else begin
            case (st_q)
               DDR_ST_LAT: begin
                  // latency counted in memory clock edges: 2 rising, or 2 then a fall
                  if (mclk_rise) lat_q <= lat_q + 3'h1;
                  if ((!half_q && mclk_rise && lat_q == 3'h1) ||
                      (half_q && mclk_fall && lat_q == 3'h2)) st_q <= DDR_ST_RD;
               end
               DDR_ST_RD: begin
                  if (act && cmd == DDR_CMD_BST && !ap_q) st_q <= DDR_ST_IDLE;
                  else if (burst_done) st_q <= DDR_ST_IDLE;
                  else if (mclk_rise || mclk_fall) beat_q <= beat_q + 4'h1;
               end
               DDR_ST_WR: begin
                  if (burst_done) st_q <= DDR_ST_IDLE;
                  else if (dqs_edge) beat_q <= beat_q + 4'h1;
               end
               default: st_q <= DDR_ST_IDLE;
            endcase
         end
      end
   end
   // write beats pass through a fifo before the array
   logic       wf_valid;
   logic       wf_ready;
   ddr_beat_s  wf_out;
   logic [MEM_AW-1:0] widx_q [`DDR_FIFO_DEPTH];
   logic [2:0] wi_wp_q, wi_rp_q;
   wire wr_push = st_q == DDR_ST_WR && dqs_edge && !burst_done;
   ddr_fifo #(.WIDTH(9), .DEPTH(`DDR_FIFO_DEPTH)) u_wfifo (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_valid (wr_push),
      .o_ready (wf_ready),
      .i_data  (wd_s2_q),
      .o_valid (wf_valid),
      .i_ready (!pd_q),
      .o_data  (wf_out)
   );
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wi_wp_q <= 3'h0;
         wi_rp_q <= 3'h0;
      end else if (i_ce) begin
         if (wr_push && wf_ready) wi_wp_q <= wi_wp_q + 3'h1;
         if (wf_valid && !pd_q)   wi_rp_q <= wi_rp_q + 3'h1;
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_ce && wr_push && wf_ready) widx_q[wi_wp_q] <= mem_idx;
   end
   // storage array
   logic [7:0] mem_q [DEPTH];
   always_ff @(posedge i_clock) begin
      if (i_ce && wf_valid && !pd_q && !wf_out.write_data_mask)
         mem_q[widx_q[wi_rp_q]] <= wf_out.data;
   end
   // read output: data and strobe change together on memory clock edges
   logic drive_q;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dq       <= 8'h00;
         o_dqs      <= 1'b0;
         o_dq_oe_n  <= 1'b1;
         o_dqs_oe_n <= 1'b1;
         drive_q    <= 1'b0;
      end else if (!cke_now && !drive_q) begin
         o_dq_oe_n  <= 1'b1;
         o_dqs_oe_n <= 1'b1;
      end else if (i_ce) begin
         drive_q    <= st_q == DDR_ST_RD && !burst_done;
         o_dq_oe_n  <= !(st_q == DDR_ST_RD && !burst_done);
         o_dqs_oe_n <= !(st_q == DDR_ST_RD && !burst_done);
         if (st_q == DDR_ST_RD && (mclk_rise || mclk_fall) && !burst_done) begin
            o_dq  <= mem_q[mem_idx];
            o_dqs <= ~beat_q[0];
         end else if (st_q != DDR_ST_RD) begin
            // the strobe holds between beats, so every beat is exactly one toggle
            o_dqs <= 1'b0;
         end
      end
   end
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wr_ready   <= 1'b0;
         o_bank_open  <= 4'h0;
         o_power_down <= 1'b1;
      end else if (i_ce) begin
         o_wr_ready   <= wf_ready;
         o_bank_open  <= open_q;
         o_power_down <= pd_q;
      end
   end
   // burst beat counters, read only by the checks below
   logic [3:0] rd_beats_q;
   logic [3:0] wr_beats_q;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_beats_q <= 4'h0;
      end else if (i_ce) begin
         if (st_q != DDR_ST_RD || rw_cmd) begin
            rd_beats_q <= 4'h0;
         end else if ((mclk_rise || mclk_fall) && !burst_done) begin
            rd_beats_q <= rd_beats_q + 4'h1;
         end
      end
   end
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_beats_q <= 4'h0;
      end else if (i_ce) begin
         if (st_q != DDR_ST_WR || rw_cmd) begin
            wr_beats_q <= 4'h0;
         end else if (wr_push && wf_ready) begin
            wr_beats_q <= wr_beats_q + 4'h1;
         end
      end
   end
   // checks watch internal state; the bench only sees the pins
   AST_CS_IGNORE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      cmd_s2_q.cs_n |-> cmd == DDR_CMD_NOP)
      else $error("command decoded while deselected");
   AST_ACT_OPENS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && act && cmd == DDR_CMD_ACT |=> open_q[$past(ba)])
      else $error("activate did not open bank");
   AST_PREALL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && act && cmd == DDR_CMD_PRE && addr[`DDR_AP_BIT] |=> open_q == 4'h0)
      else $error("precharge all left a bank open");
   AST_PD_DECODE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      pd_q |-> !act)
      else $error("command taken in power-down");
   AST_RD_DRIVE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !o_dqs_oe_n |-> $past(st_q) == DDR_ST_RD)
      else $error("strobe driven outside read");
   AST_BURST_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      beat_q <= len_q)
      else $error("burst ran past its length");
   AST_MRS_LOAD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && act && cmd == DDR_CMD_MRS && ba == 2'h0 |=> mr_q == $past(addr))
      else $error("mode register not loaded");
   AST_OUT_OFF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !cke_now && !drive_q |=> o_dq_oe_n)
      else $error("data driven with clock enable low");
   AST_PRE_ONE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && act && cmd == DDR_CMD_PRE && !addr[`DDR_AP_BIT] |=> !open_q[$past(ba)])
      else $error("single precharge left its bank open");
   AST_AP_CLOSE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && burst_done && ap_q && !(act && cmd == DDR_CMD_ACT) |=> !open_q[$past(ap_bank_q)])
      else $error("auto precharge left the bank open");
   AST_RD_COUNT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_q == DDR_ST_RD && burst_done |-> rd_beats_q == len_q)
      else $error("read burst gave the wrong number of beats");
   AST_WR_COUNT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_q == DDR_ST_WR && burst_done |-> wr_beats_q == len_q)
      else $error("write burst stored the wrong number of beats");
   AST_DQS_TOGGLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && cke_now && st_q == DDR_ST_RD && (mclk_rise || mclk_fall) && !burst_done
         |=> o_dqs != $past(o_dqs))
      else $error("read beat without a strobe edge");
   AST_DQ_WITH_DQS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !o_dq_oe_n && $changed(o_dq) |-> $changed(o_dqs))
      else $error("read data moved without the strobe");
   AST_OE_PAIR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_dq_oe_n == o_dqs_oe_n)
      else $error("data and strobe drive enables differ");
   AST_LAT_HALF: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && st_q == DDR_ST_LAT && half_q && !mclk_fall && !rw_cmd |=> st_q == DDR_ST_LAT)
      else $error("half-cycle latency left off a falling edge");
   AST_LAT_WHOLE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && st_q == DDR_ST_LAT && !half_q && !mclk_rise && !rw_cmd |=> st_q == DDR_ST_LAT)
      else $error("whole-cycle latency left off a rising edge");
   AST_PD_FLAG: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce |=> o_power_down == $past(pd_q))
      else $error("power-down flag does not follow state");
   AST_BANK_FLAG: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce |=> o_bank_open == $past(open_q))
      else $error("open-row flags do not follow state");
   AST_MASK_KEEP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_ce && wf_valid && !pd_q && wf_out.write_data_mask
         |=> mem_q[$past(widx_q[wi_rp_q])] == $past(mem_q[widx_q[wi_rp_q]]))
      else $error("masked beat changed memory");
   AST_BL_LEGAL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      st_q != DDR_ST_IDLE |-> len_q == 4'h2 || len_q == 4'h4 || len_q == 4'h8)
      else $error("burst length outside 2, 4 and 8");
   COV_READ: cover property (@(posedge i_clock) st_q == DDR_ST_RD);
   COV_WRITE: cover property (@(posedge i_clock) wr_push);
   COV_AUTOPRE: cover property (@(posedge i_clock) burst_done && ap_q);
   COV_INTERLEAVED: cover property (@(posedge i_clock) st_q == DDR_ST_RD && interl);
   COV_MASKED: cover property (@(posedge i_clock) wr_push && wd_s2_q[0]);
endmodule // ddr_sdram

/* File: tb/ddr_ctrl_model.sv */
// controller-side model: memory clock, commands and write bursts
`timescale 1ns/10ps
module ddr_ctrl_model import ddr_pkg::*; #(
   parameter int STARTUP_NS = 200000
) (
   output logic       o_mclk,     // memory clock
   output logic       o_cke,      // clock enable
   output ddr_cmd_s   o_cmd,      // command pins
   output logic [7:0] o_dq,       // write data
   output logic       o_dq_oe_n,  // low drives data
   output logic       o_dqs,      // write strobe
   output logic       o_dqs_oe_n, // low drives strobe
   output logic       o_mask      // write mask
);
   localparam logic [2:0] CODE [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h6, 3'h2, 3'h1, 3'h0};
   localparam ddr_cmd_s   IDLE     = {4'hF, 15'h0000};
   initial begin
      o_mclk = 1'b0;
      o_cke = 1'b0;
      o_cmd = IDLE;
      o_dq = 8'h00;
      o_dq_oe_n = 1'b1;
      o_dqs = 1'b0;
      o_dqs_oe_n = 1'b1;
      o_mask = 1'b0;
   end
   always #80 o_mclk = ~o_mclk;
   // pins change on the fall so they are stable across the sampling rise
   task automatic issue(input ddr_cmd_e op, input logic [1:0] ba, input logic [12:0] a,
                        input logic cs_n);
      @(negedge o_mclk);
      o_cmd = {cs_n, CODE[op], ba, a};
      @(negedge o_mclk);
      o_cmd = IDLE;
   endtask
   task automatic set_cke(input logic v);
      @(negedge o_mclk);
      o_cke = v;
   endtask
   task automatic power_up();
      #(STARTUP_NS);
      set_cke(1'b1);
      issue(DDR_CMD_NOP, 2'h0, 13'h0000, 1'b0);
      issue(DDR_CMD_PRE, 2'h0, 13'h0400, 1'b0);
      issue(DDR_CMD_MRS, 2'h1, 13'h0000, 1'b0);
      issue(DDR_CMD_MRS, 2'h0, 13'h0122, 1'b0);
      repeat (2) issue(DDR_CMD_REF, 2'h0, 13'h0000, 1'b0);
      repeat (200) @(posedge o_mclk);
   endtask
   // each strobe edge sits 40 ns inside its beat
   task automatic write_burst(input logic [1:0] ba, input logic [12:0] a,
                              input logic [63:0] d, input logic [7:0] m, input int n);
      // take the strobe low before the command, so the bus turnaround edge lands while idle
      o_dq_oe_n = 1'b0;
      o_dqs_oe_n = 1'b0;
      o_dqs = 1'b0;
      issue(DDR_CMD_WR, ba, a, 1'b0);
      #40;
      for (int i = 0; i < n; i++) begin
         o_dq = d[8*i +: 8];
         o_mask = m[i];
         #40 o_dqs = ~o_dqs;
         #40;
      end
      o_dq_oe_n = 1'b1;
      o_dqs_oe_n = 1'b1;
   endtask
endmodule // ddr_ctrl_model

/* File: tb/ddr_sdram_command_data_interface_tb_top.sv */
// self-checking bench for the ddr sdram model
`timescale 1ns/10ps
module ddr_sdram_command_data_interface_tb_top import ddr_pkg::*;;
   logic       i_clock = 1'b0;
   logic       i_rst_n = 1'b0;
   logic       i_ce = 1'b1;
   int         failures = 0;
   int         comparisons = 0;
   logic [7:0] rd_q [$];
   logic       dqs_prev = 1'b0;
   logic       dqs_last = 1'b1;
   logic [7:0] dq_last = 8'h00;
   ddr_cmd_s   cmd;
   logic [7:0] c_dq, d_dq, dq_bus;
   logic       mclk, cke, c_dq_oe_n, c_dqs, c_dqs_oe_n, c_mask, dqs_bus;
   logic       d_dq_oe_n, d_dqs, d_dqs_oe_n, wr_ready, power_down;
   logic [3:0] bank_open;
   always #5 i_clock = ~i_clock;
   // a released line shows the inverse of its last driven level, never a held copy
   assign dq_bus = !d_dq_oe_n ? d_dq : !c_dq_oe_n ? c_dq : ~dq_last;
   assign dqs_bus = !d_dqs_oe_n ? d_dqs : !c_dqs_oe_n ? c_dqs : ~dqs_last;
   always @(posedge i_clock) begin
      if (!d_dq_oe_n || !c_dq_oe_n) dq_last <= dq_bus;
      if (!d_dqs_oe_n || !c_dqs_oe_n) dqs_last <= dqs_bus;
      dqs_prev <= d_dqs;
      if (d_dq_oe_n === 1'b0 && d_dqs !== dqs_prev) rd_q.push_back(d_dq);
      if (c_dqs_oe_n === 1'b0 && d_dqs_oe_n !== 1'b1) begin
         failures++;
         $display("BAD %0t strobe driven during write", $time);
      end
   end
   ddr_sdram DUT (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_mclk(mclk), .i_cke(cke),
      .i_cmd(cmd), .i_dq(dq_bus), .o_dq(d_dq), .o_dq_oe_n(d_dq_oe_n), .i_dqs(dqs_bus),
      .o_dqs(d_dqs), .o_dqs_oe_n(d_dqs_oe_n), .i_write_data_mask(c_mask),
      .o_wr_ready(wr_ready), .o_bank_open(bank_open), .o_power_down(power_down));
   ddr_ctrl_model CTRL (
      .o_mclk(mclk), .o_cke(cke), .o_cmd(cmd), .o_dq(c_dq), .o_dq_oe_n(c_dq_oe_n),
      .o_dqs(c_dqs), .o_dqs_oe_n(c_dqs_oe_n), .o_mask(c_mask));
   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask
   // commands cross two sync flops; 30 core cycles covers it
   task automatic settle();
      repeat (30) @(posedge i_clock);
      #1;
   endtask
   task automatic mrs(input logic [2:0] bl, input logic bt, input logic [2:0] cl);
      CTRL.issue(DDR_CMD_MRS, 2'h0, {6'h00, cl, bt, bl}, 1'b0);
   endtask
   task automatic read_check(input logic [1:0] ba, input logic [12:0] a,
                             input logic [63:0] exp, input int n);
      int k;
      rd_q.delete();
      CTRL.issue(DDR_CMD_RD, ba, a, 1'b0);
      for (k = 0; k < 600 && !(rd_q.size() >= n && d_dq_oe_n === 1'b1); k++) @(posedge i_clock);
      if (k == 600) begin
         failures++;
         $display("BAD %0t read burst never completed", $time);
         tally_and_finish();
      end
      check(8'(rd_q.size()), 8'(n), "beat count");
      for (k = 0; k < n && k < rd_q.size(); k++) check(rd_q[k], exp[8*k +: 8], "read beat");
   endtask
   task automatic sc_banks();
      CTRL.issue(DDR_CMD_ACT, 2'h1, 13'h0005, 1'b0);
      CTRL.issue(DDR_CMD_ACT, 2'h0, 13'h0005, 1'b1);
      CTRL.issue(DDR_CMD_ACT, 2'h2, 13'h1FFF, 1'b0);
      settle();
      check({4'h0, bank_open}, 8'h06, "open rows");
   endtask
   task automatic sc_freeze();
      i_ce = 1'b0;
      CTRL.issue(DDR_CMD_ACT, 2'h3, 13'h0000, 1'b0);
      settle();
      i_ce = 1'b1;
      settle();
      check({4'h0, bank_open}, 8'h00, "command while frozen");
   endtask
   task automatic sc_orders();
      mrs(3'h3, 1'b0, 3'h2);
      CTRL.write_burst(2'h1, 13'h0000, 64'h8786858483828180, 8'h00, 8);
      read_check(2'h1, 13'h0003, 64'h8281808786858483, 8);
      mrs(3'h3, 1'b1, 3'h2);
      read_check(2'h1, 13'h0005, 64'h8283808186878485, 8);
      mrs(3'h2, 1'b1, 3'h2);
      read_check(2'h1, 13'h0001, 64'h0000000082838081, 4);
      mrs(3'h2, 1'b0, 3'h6);
      read_check(2'h1, 13'h0001, 64'h0000000080838281, 4);
      mrs(3'h1, 1'b0, 3'h2);
      read_check(2'h1, 13'h0005, 64'h0000000000008485, 2);
   endtask
   task automatic sc_mask();
      mrs(3'h2, 1'b0, 3'h2);
      CTRL.write_burst(2'h1, 13'h0008, 64'hA3A2A1A0, 8'h00, 4);
      CTRL.write_burst(2'h1, 13'h0008, 64'hB3B2B1B0, 8'h05, 4);
      read_check(2'h1, 13'h0008, 64'hB3A2B1A0, 4);
   endtask
   task automatic sc_precharge();
      CTRL.write_burst(2'h2, 13'h0400, 64'hC3C2C1C0, 8'h00, 4);
      settle();
      check({4'h0, bank_open}, 8'h02, "auto precharge");
      CTRL.issue(DDR_CMD_ACT, 2'h3, 13'h0000, 1'b0);
      CTRL.issue(DDR_CMD_PRE, 2'h1, 13'h0000, 1'b0);
      settle();
      check({4'h0, bank_open}, 8'h08, "single precharge");
      CTRL.issue(DDR_CMD_PRE, 2'h0, 13'h0400, 1'b0);
      settle();
      check({4'h0, bank_open}, 8'h00, "precharge all");
   endtask
   task automatic sc_power_down();
      CTRL.set_cke(1'b0);
      settle();
      check({7'h00, power_down}, 8'h01, "clock enable low");
      CTRL.issue(DDR_CMD_ACT, 2'h0, 13'h0001, 1'b0);
      settle();
      check({4'h0, bank_open}, 8'h00, "command while asleep");
      CTRL.set_cke(1'b1);
      CTRL.issue(DDR_CMD_ACT, 2'h0, 13'h0001, 1'b0);
      settle();
      check({3'h0, power_down, bank_open}, 8'h01, "awake and active");
   endtask
   initial begin
      repeat (16) @(posedge i_clock);
      #1 i_rst_n = 1'b1;
      settle();
      check({5'h00, d_dq_oe_n, d_dqs_oe_n, power_down}, 8'h07, "start state");
      CTRL.power_up();
      settle();
      check({5'h00, d_dq_oe_n, d_dqs_oe_n, power_down}, 8'h06, "after start-up");
      check({7'h00, wr_ready}, 8'h01, "write buffer room");
      sc_freeze();
      sc_banks();
      sc_orders();
      sc_mask();
      sc_precharge();
      sc_power_down();
      tally_and_finish();
   end
endmodule // ddr_sdram_command_data_interface_tb_top
